/* File: rtl/clock_gate_map.svh */
// register map, field positions and reset values of the peripheral clock gate bank
`ifndef CLOCK_GATE_MAP_SVH
`define CLOCK_GATE_MAP_SVH

`define FAST_GATES_OFFSET 12'h018
`define SLOW_GATES_OFFSET 12'h01C
`define GATES_RESET 32'h0000_0000

`define FAST_TIMER_TEN_CLOCK_GATE 21
`define FAST_TIMER_NINE_CLOCK_GATE 20
`define FAST_TIMER_EIGHT_CLOCK_GATE 19
`define FAST_THIRD_CONVERTER_CLOCK_GATE 15
`define FAST_FIRST_SERIAL_PORT_CLOCK_GATE 14
`define FAST_ADVANCED_TIMER_SEVEN_GATE 13
`define FAST_FIRST_SPI_CLOCK_GATE 12
`define FAST_ADVANCED_TIMER_ZERO_GATE 11
`define FAST_SECOND_CONVERTER_CLOCK_GATE 10
`define FAST_FIRST_CONVERTER_CLOCK_GATE 9
`define FAST_PORT_G_CLOCK_GATE 8
`define FAST_PORT_A_CLOCK_GATE 2
`define FAST_ALT_FUNCTION_IO_CLOCK_GATE 0

`define SLOW_DAC_CLOCK_GATE 29
`define SLOW_POWER_UNIT_CLOCK_GATE 28
`define SLOW_BACKUP_INTERFACE_CLOCK_GATE 27
`define SLOW_SECOND_CAN_CLOCK_GATE 26
`define SLOW_FIRST_CAN_CLOCK_GATE 25
`define SLOW_SECOND_I2C_CLOCK_GATE 22
`define SLOW_FIRST_I2C_CLOCK_GATE 21
`define SLOW_FIFTH_SERIAL_PORT_CLOCK_GATE 20
`define SLOW_SECOND_SERIAL_PORT_CLOCK_GATE 17
`define SLOW_THIRD_SPI_CLOCK_GATE 15
`define SLOW_SECOND_SPI_CLOCK_GATE 14
`define SLOW_WINDOW_WATCHDOG_CLOCK_GATE 11
`define SLOW_TIMER_THIRTEEN_CLOCK_GATE 8
`define SLOW_TIMER_ELEVEN_CLOCK_GATE 6
`define SLOW_TIMER_SIX_CLOCK_GATE 5
`define SLOW_TIMER_FIVE_CLOCK_GATE 4
`define SLOW_TIMER_THREE_CLOCK_GATE 2
`define SLOW_TIMER_TWO_CLOCK_GATE 1

`endif

/* File: rtl/clock_gate_pkg.sv */
// types shared by the peripheral clock gate bank
`default_nettype none
package clock_gate_pkg;
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
    typedef enum logic {
        PH_WAIT,
        PH_ANSWER
    } apb_phase_e;
endpackage
`default_nettype wire

/* File: rtl/peripheral_clock_gate_bank.sv */
// apb register bank holding the per-peripheral clock gates and their gating cells
//
// The APB register port was left to the implementer.
`include "clock_gate_map.svh"
`default_nettype none
module peripheral_clock_gate_bank
    import clock_gate_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    output var logic [31:0] fast_gate_en,
    output var logic [31:0] slow_gate_en,
    output logic [31:0] fast_gclk,
    output logic [31:0] slow_gclk
);

    localparam word_t FAST_TIMERS = (word_t'(1) << `FAST_TIMER_TEN_CLOCK_GATE)
        | (word_t'(1) << `FAST_TIMER_NINE_CLOCK_GATE) | (word_t'(1) << `FAST_TIMER_EIGHT_CLOCK_GATE);
    localparam word_t FAST_CONVS = (word_t'(1) << `FAST_THIRD_CONVERTER_CLOCK_GATE)
        | (word_t'(1) << `FAST_SECOND_CONVERTER_CLOCK_GATE) | (word_t'(1) << `FAST_FIRST_CONVERTER_CLOCK_GATE);
    localparam word_t FAST_SERIAL = (word_t'(1) << `FAST_FIRST_SERIAL_PORT_CLOCK_GATE)
        | (word_t'(1) << `FAST_FIRST_SPI_CLOCK_GATE);
    localparam word_t FAST_ADV = (word_t'(1) << `FAST_ADVANCED_TIMER_SEVEN_GATE)
        | (word_t'(1) << `FAST_ADVANCED_TIMER_ZERO_GATE);
    localparam word_t FAST_PORTS = (word_t'(1) << (`FAST_PORT_G_CLOCK_GATE + 1))
        - (word_t'(1) << `FAST_PORT_A_CLOCK_GATE);
    localparam word_t FAST_ALT = word_t'(1) << `FAST_ALT_FUNCTION_IO_CLOCK_GATE;
    localparam word_t FAST_MASK = FAST_TIMERS | FAST_CONVS | FAST_SERIAL | FAST_ADV | FAST_PORTS | FAST_ALT;

    localparam word_t SLOW_MISC = (word_t'(1) << `SLOW_DAC_CLOCK_GATE)
        | (word_t'(1) << `SLOW_POWER_UNIT_CLOCK_GATE) | (word_t'(1) << `SLOW_BACKUP_INTERFACE_CLOCK_GATE);
    localparam word_t SLOW_CAN = (word_t'(1) << `SLOW_SECOND_CAN_CLOCK_GATE)
        | (word_t'(1) << `SLOW_FIRST_CAN_CLOCK_GATE);
    localparam word_t SLOW_I2C = (word_t'(1) << `SLOW_SECOND_I2C_CLOCK_GATE)
        | (word_t'(1) << `SLOW_FIRST_I2C_CLOCK_GATE);
    localparam word_t SLOW_SERIAL = (word_t'(1) << (`SLOW_FIFTH_SERIAL_PORT_CLOCK_GATE + 1))
        - (word_t'(1) << `SLOW_SECOND_SERIAL_PORT_CLOCK_GATE);
    localparam word_t SLOW_SPI = (word_t'(1) << `SLOW_THIRD_SPI_CLOCK_GATE)
        | (word_t'(1) << `SLOW_SECOND_SPI_CLOCK_GATE) | (word_t'(1) << `SLOW_WINDOW_WATCHDOG_CLOCK_GATE);
    localparam word_t SLOW_TIM_HI = (word_t'(1) << (`SLOW_TIMER_THIRTEEN_CLOCK_GATE + 1))
        - (word_t'(1) << `SLOW_TIMER_ELEVEN_CLOCK_GATE);
    localparam word_t SLOW_TIM_LO = (word_t'(1) << `SLOW_TIMER_SIX_CLOCK_GATE)
        | (word_t'(1) << `SLOW_TIMER_FIVE_CLOCK_GATE) | (word_t'(1) << `SLOW_TIMER_THREE_CLOCK_GATE)
        | (word_t'(1) << `SLOW_TIMER_TWO_CLOCK_GATE);
    localparam word_t SLOW_MASK = SLOW_MISC | SLOW_CAN | SLOW_I2C | SLOW_SERIAL | SLOW_SPI
        | SLOW_TIM_HI | SLOW_TIM_LO;

    apb_phase_e phase_q;
    apb_phase_e phase_d;
    word_t fast_q;
    word_t fast_d;
    word_t slow_q;
    word_t slow_d;
    word_t rdata_q;
    word_t rdata_d;
    logic ready_q;
    logic err_q;
    logic out_of_reset_q;

    wire logic access = psel & penable;
    wire logic done = access & ready_q;
    wire logic hit_fast = (paddr == `FAST_GATES_OFFSET);
    wire logic hit_slow = (paddr == `SLOW_GATES_OFFSET);
    wire logic hit_any = hit_fast | hit_slow;
    wire logic fast_wr = done & pwrite & hit_fast;
    wire logic slow_wr = done & pwrite & hit_slow;
    wire word_t lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    assign fast_d = fast_wr ? ((fast_q & ~lane_mask) | (pwdata & lane_mask & FAST_MASK)) : fast_q;
    assign slow_d = slow_wr ? ((slow_q & ~lane_mask) | (pwdata & lane_mask & SLOW_MASK)) : slow_q;
    // one wait state so every bus answer leaves a flip-flop
    assign phase_d = (phase_q == PH_WAIT) ? (access ? PH_ANSWER : PH_WAIT) : PH_WAIT;
    wire logic ready_d = (phase_d == PH_ANSWER);
    wire logic err_d = ready_d & ~hit_any;
    wire word_t read_word = hit_fast ? fast_q : (hit_slow ? slow_q : `GATES_RESET);
    // prdata idles at zero so a stale word never shows outside its answer cycle
    assign rdata_d = (ready_d & ~pwrite) ? read_word : `GATES_RESET;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_q <= `GATES_RESET;
            slow_q <= `GATES_RESET;
        end else begin
            fast_q <= fast_d;
            slow_q <= slow_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_WAIT;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= `GATES_RESET;
        end else begin
            phase_q <= phase_d;
            ready_q <= ready_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_of_reset_q <= 1'b0;
        end else begin
            out_of_reset_q <= 1'b1;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign fast_gate_en = fast_q;
    assign slow_gate_en = slow_q;

    for (genvar i = 0; i < 32; i++) begin : g_gate
        if (FAST_MASK[i]) begin : g_fast
            logic en_l;
            // latch gating cell
            // the enable only moves while pclk is low, so no pulse is ever cut short
            always_latch begin
                if (!pclk) begin
                    en_l <= fast_q[i];
                end
            end
            assign fast_gclk[i] = pclk & en_l;
        end else begin : g_fast_off
            assign fast_gclk[i] = 1'b0;
        end
        if (SLOW_MASK[i]) begin : g_slow
            logic en_l;
            always_latch begin
                if (!pclk) begin
                    en_l <= slow_q[i];
                end
            end
            assign slow_gclk[i] = pclk & en_l;
        end else begin : g_slow_off
            assign slow_gclk[i] = 1'b0;
        end
    end

    AST_FAST_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        !out_of_reset_q |-> fast_gate_en == `GATES_RESET)
        else $error("fast gates not zero after reset");

    AST_SLOW_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        !out_of_reset_q |-> slow_gate_en == `GATES_RESET)
        else $error("slow gates not zero after reset");

    AST_FAST_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF) |=> fast_gate_en == ($past(pwdata) & FAST_MASK))
        else $error("fast gate write lost");

    AST_SLOW_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF) |=> slow_gate_en == ($past(pwdata) & SLOW_MASK))
        else $error("slow gate write lost");

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(fast_wr || slow_wr) |=> $stable(fast_gate_en) && $stable(slow_gate_en))
        else $error("gate changed without a write");

    AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        ((fast_gate_en & ~FAST_MASK) == `GATES_RESET) && ((slow_gate_en & ~SLOW_MASK) == `GATES_RESET))
        else $error("reserved gate bit set");

    AST_TIMER_TEN: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb[2]) |=> fast_gate_en[`FAST_TIMER_TEN_CLOCK_GATE]
            == $past(pwdata[`FAST_TIMER_TEN_CLOCK_GATE]))
        else $error("timer ten gate wrong");

    AST_LOW_TIMERS: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb[0]) |=> slow_gate_en[7:0] == ($past(pwdata[7:0]) & SLOW_MASK[7:0]))
        else $error("slow low gates wrong");

    AST_ANSWER_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready) |=> pready ##1 !pready)
        else $error("answer not one wait state");

    AST_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !pwrite && hit_slow) |-> prdata == slow_gate_en)
        else $error("slow readback mismatch");

    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !hit_any) |-> pslverr && prdata == `GATES_RESET)
        else $error("unmapped access not flagged");

    AST_TIMERS_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF)
            |=> (fast_gate_en & FAST_TIMERS) == ($past(pwdata) & FAST_TIMERS))
        else $error("fast timer gates not writable");

    AST_CONVERTERS: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF)
            |=> (fast_gate_en & FAST_CONVS) == ($past(pwdata) & FAST_CONVS))
        else $error("converter gates not writable");

    AST_SERIAL_SPI_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF)
            |=> (fast_gate_en & FAST_SERIAL) == ($past(pwdata) & FAST_SERIAL))
        else $error("fast serial and spi gates not writable");

    AST_ADVANCED_TIMERS: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF)
            |=> (fast_gate_en & FAST_ADV) == ($past(pwdata) & FAST_ADV))
        else $error("advanced timer gates not writable");

    AST_IO_PORTS: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF)
            |=> (fast_gate_en & FAST_PORTS) == ($past(pwdata) & FAST_PORTS))
        else $error("io port gates not writable");

    AST_ALT_IO: assert property (@(posedge pclk) disable iff (!presetn)
        (fast_wr && pstrb == 4'hF)
            |=> (fast_gate_en & FAST_ALT) == ($past(pwdata) & FAST_ALT))
        else $error("alternate io gate not writable");

    AST_ANALOG_POWER: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_MISC) == ($past(pwdata) & SLOW_MISC))
        else $error("analog power backup gates not writable");

    AST_CAN: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_CAN) == ($past(pwdata) & SLOW_CAN))
        else $error("can gates not writable");

    AST_I2C: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_I2C) == ($past(pwdata) & SLOW_I2C))
        else $error("i2c gates not writable");

    AST_SERIAL_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_SERIAL) == ($past(pwdata) & SLOW_SERIAL))
        else $error("slow serial gates not writable");

    AST_SPI_WATCHDOG: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_SPI) == ($past(pwdata) & SLOW_SPI))
        else $error("spi and watchdog gates not writable");

    AST_TIMERS_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_TIM_HI) == ($past(pwdata) & SLOW_TIM_HI))
        else $error("upper slow timer gates not writable");

    AST_TIMERS_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_wr && pstrb == 4'hF)
            |=> (slow_gate_en & SLOW_TIM_LO) == ($past(pwdata) & SLOW_TIM_LO))
        else $error("lower slow timer gates not writable");

    AST_FAST_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !pwrite && hit_fast) |-> prdata == fast_gate_en)
        else $error("fast readback mismatch");

    AST_FAST_LANES: assert property (@(posedge pclk) disable iff (!presetn)
        fast_wr
            |=> (fast_gate_en & $past(lane_mask)) == ($past(pwdata) & $past(lane_mask) & FAST_MASK))
        else $error("fast strobed lanes not written");

    AST_SLOW_LANES: assert property (@(posedge pclk) disable iff (!presetn)
        slow_wr
            |=> (slow_gate_en & $past(lane_mask)) == ($past(pwdata) & $past(lane_mask) & SLOW_MASK))
        else $error("slow strobed lanes not written");

    AST_FAST_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        fast_wr
            |=> (fast_gate_en & ~$past(lane_mask)) == ($past(fast_gate_en) & ~$past(lane_mask)))
        else $error("fast unstrobed lanes changed");

    AST_SLOW_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        slow_wr
            |=> (slow_gate_en & ~$past(lane_mask)) == ($past(slow_gate_en) & ~$past(lane_mask)))
        else $error("slow unstrobed lanes changed");

    AST_FAST_CHANGE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(fast_gate_en) |-> $past(fast_wr))
        else $error("fast gates moved without a write");

    AST_SLOW_CHANGE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(slow_gate_en) |-> $past(slow_wr))
        else $error("slow gates moved without a write");

    // sampled in the high phase: a gate written at a rising edge shows from the next high phase on
    AST_FAST_GCLK: assert property (@(negedge pclk) disable iff (!presetn)
        fast_gclk == $past(fast_gate_en))
        else $error("fast gated clock does not follow its gate");

    AST_SLOW_GCLK: assert property (@(negedge pclk) disable iff (!presetn)
        slow_gclk == $past(slow_gate_en))
        else $error("slow gated clock does not follow its gate");

    AST_PRDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == `GATES_RESET)
        else $error("read data outside answer cycle");

    AST_PRDATA_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && pwrite) |-> prdata == `GATES_RESET)
        else $error("read data during write answer");

    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

    AST_MAPPED_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (done && hit_any) |-> !pslverr)
        else $error("mapped access flagged as error");

    AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready longer than one cycle");

    AST_UNMAPPED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && !hit_any) |=> $stable(fast_gate_en) && $stable(slow_gate_en))
        else $error("unmapped write changed a gate");

    AST_RESET_BUS: assert property (@(posedge pclk) disable iff (!presetn)
        !out_of_reset_q |-> !pready && !pslverr && prdata == `GATES_RESET)
        else $error("bus outputs not idle after reset");

endmodule // peripheral_clock_gate_bank
`default_nettype wire

/* File: tb/peripheral_clock_gate_bank_tb_top.sv */
// self-checking bench for the peripheral clock gate bank, reference model kept in bench variables
`include "clock_gate_map.svh"
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module peripheral_clock_gate_bank_tb_top
    import clock_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // writable positions; everything else is reserved and must read back zero
    localparam word_t FAST_MASK = 32'h0038_FFFD;
    localparam word_t SLOW_MASK = 32'h3E7E_C9F6;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    addr_t paddr = '0;
    word_t pwdata = '0;
    logic [3:0] pstrb = '0;
    word_t prdata, fast_gate_en, slow_gate_en, fast_gclk, slow_gclk;
    logic pready, pslverr;
    int err_count = 0;
    int tests_run = 0;
    word_t mf = '0;
    word_t ms = '0;
    word_t r = 32'h0000_005C;
    word_t wd = '0;
    addr_t tab [6];
    peripheral_clock_gate_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_gate_en(fast_gate_en), .slow_gate_en(slow_gate_en), .fast_gclk(fast_gclk),
        .slow_gclk(slow_gclk));
    always #5 pclk = ~pclk;
    function automatic word_t lfsr(input word_t v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic results;
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // entered right after a rising edge; returns one edge after the request is released
    task automatic apb(input logic w, input addr_t a, input word_t d, input logic [3:0] s,
                       output word_t rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic access(input logic w, input addr_t a, input word_t d, input logic [3:0] s);
        word_t rd, ex, ln;
        logic err, hit_f, hit_s;
        hit_f = (a === `FAST_GATES_OFFSET);
        hit_s = (a === `SLOW_GATES_OFFSET);
        ex = hit_f ? mf : (hit_s ? ms : '0);
        ln = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        apb(w, a, d, s, rd, err);
        `CHK("pslverr", !(hit_f || hit_s), err)
        if (!w) `CHK("prdata", ex, rd)
        if (w && hit_f) mf = (mf & ~ln) | (d & ln & FAST_MASK);
        if (w && hit_s) ms = (ms & ~ln) | (d & ln & SLOW_MASK);
        `CHK("fast_gate_en", mf, fast_gate_en)
        `CHK("slow_gate_en", ms, slow_gate_en)
    endtask
    // gated clocks follow their gates in the high phase and stay low in the low phase
    task automatic chk_gclk;
        @(posedge pclk);
        #2;
        `CHK("fast_gclk high", mf, fast_gclk)
        `CHK("slow_gclk high", ms, slow_gclk)
        #5;
        `CHK("fast_gclk low", 32'h0000_0000, fast_gclk)
        `CHK("slow_gclk low", 32'h0000_0000, slow_gclk)
        @(posedge pclk);
    endtask
    initial begin
        tab = '{`FAST_GATES_OFFSET, `SLOW_GATES_OFFSET, 12'h000, 12'h019, 12'h014, 12'h020};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        access(1'b0, `FAST_GATES_OFFSET, '0, 4'h0);
        access(1'b0, `SLOW_GATES_OFFSET, '0, 4'h0);
        chk_gclk();
        // walking one across both registers, reserved positions included
        for (int i = 0; i < 32; i++) begin
            access(1'b1, `FAST_GATES_OFFSET, 32'h0000_0001 << i, 4'hF);
            access(1'b1, `SLOW_GATES_OFFSET, 32'h0000_0001 << i, 4'hF);
            access(1'b0, `FAST_GATES_OFFSET, '0, 4'h0);
            access(1'b0, `SLOW_GATES_OFFSET, '0, 4'h0);
            chk_gclk();
        end
        access(1'b1, `FAST_GATES_OFFSET, 32'hFFFF_FFFF, 4'hF);
        access(1'b1, `SLOW_GATES_OFFSET, 32'hFFFF_FFFF, 4'hF);
        // random traffic with partial strobes and unmapped addresses mixed in
        for (int k = 0; k < 60; k++) begin
            r = lfsr(r);
            wd = lfsr(r) & ((r[2:0] % 6 == 1) ? SLOW_MASK : FAST_MASK);
            access(r[8], tab[r[2:0] % 6], wd, r[7:4]);
            if (k % 4 == 0) chk_gclk();
        end
        // second reset in mid-run clears every gate
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK("fast_gate_en reset", 32'h0000_0000, fast_gate_en)
        `CHK("slow_gate_en reset", 32'h0000_0000, slow_gate_en)
        `CHK("fast_gclk reset", 32'h0000_0000, fast_gclk)
        `CHK("slow_gclk reset", 32'h0000_0000, slow_gclk)
        presetn <= 1'b1;
        mf = '0;
        ms = '0;
        @(posedge pclk);
        access(1'b0, `SLOW_GATES_OFFSET, '0, 4'h0);
        access(1'b0, `FAST_GATES_OFFSET, '0, 4'h0);
        chk_gclk();
        results();
    end
endmodule // peripheral_clock_gate_bank_tb_top
`undef CHK
`default_nettype wire
